// ==== ccsr_pkg.sv ====
// package of constants and types for the charger control and status registers
package ccsr_pkg;

  // ******************************************************************
  // register command codes
  // ******************************************************************
  localparam logic [7:0] CMD_ICHARGE_REGIONS = 8'h28;
  localparam logic [7:0] CMD_OPTION_BITS     = 8'h29;
  localparam logic [7:0] CMD_CYCLE_MINUTES   = 8'h30;
  localparam logic [7:0] CMD_CV_SECONDS      = 8'h31;
  localparam logic [7:0] CMD_PHASE_ONEHOT    = 8'h34;
  localparam logic [7:0] CMD_LOOP_FLAGS      = 8'h35;
  localparam logic [7:0] CMD_ALERT_FLAGS     = 8'h36;

  // ******************************************************************
  // field positions and reset values
  // ******************************************************************
  localparam int          ICH_R4_LSB       = 10;
  localparam int          ICH_R3_LSB       = 5;
  localparam int          ICH_R2_LSB       = 0;
  localparam int          ICH_CODE_W       = 5;
  localparam logic [4:0]  ICH_R4_RESET     = 5'h1F;
  localparam logic [4:0]  ICH_R3_RESET     = 5'h1F;
  localparam logic [4:0]  ICH_R2_RESET     = 5'h0F;
  localparam int          OPT_CX_TERM_BIT  = 2;
  localparam int          OPT_TEMP_QUAL_BIT = 0;
  localparam logic [2:0]  OPT_RESET        = 3'h1;
  localparam int          ALERT_TELEM_BIT  = 15;
  localparam logic [15:0] ALERT_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [15:0] COUNT_SAT        = 16'hFFFF;

  // ******************************************************************
  // one-hot charger phase codes
  // ******************************************************************
  localparam logic [12:0] PH_DETECT_FAILED = 13'h1000;
  localparam logic [12:0] PH_DETECTING     = 13'h0800;
  localparam logic [12:0] PH_SUSPENDED     = 13'h0100;
  localparam logic [12:0] PH_PRECHARGE     = 13'h0080;
  localparam logic [12:0] PH_MAIN_CHARGING = 13'h0040;
  localparam logic [12:0] PH_THERM_PAUSE   = 13'h0020;
  localparam logic [12:0] PH_TIMER_DONE    = 13'h0010;
  localparam logic [12:0] PH_CX_DONE       = 13'h0008;
  localparam logic [12:0] PH_TIME_FAULT    = 13'h0004;
  localparam logic [12:0] PH_MISSING       = 13'h0002;
  localparam logic [12:0] PH_SHORT         = 13'h0001;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam longint CLK_PERIOD_NS  = 4;
  localparam longint SECOND_NS      = 1_000_000_000;
  localparam longint SECOND_CYCLES  = SECOND_NS / CLK_PERIOD_NS;
  localparam int     MINUTE_SECONDS = 60;

  typedef enum logic [3:0] {
    ST_SUSPENDED,
    ST_DETECTING,
    ST_DETECT_FAILED,
    ST_PRECHARGE,
    ST_MAIN_CHARGING,
    ST_THERM_PAUSE,
    ST_TIMER_DONE,
    ST_CX_DONE,
    ST_TIME_FAULT,
    ST_MISSING,
    ST_SHORT
  } ccsr_state_t;

endpackage

// ==== ccsr_sync2.sv ====
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module ccsr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ccsr_sync_t;

  ccsr_sync_t s_reg;
  ccsr_sync_t s_next;

  always_comb begin
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule

// ==== ccsr_tick_div.sv ====
// enable divider that pulses once every COUNT enabled cycles
`timescale 1ns/1ps
module ccsr_tick_div #(
  parameter int COUNT = 60
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic en,
  input  wire logic clr,
  output logic      tick
);

  localparam int CW = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } ccsr_div_t;

  ccsr_div_t d_reg;
  ccsr_div_t d_next;

  always_comb begin
    d_next      = d_reg;
    d_next.tick = 1'b0;
    if (clr) begin
      d_next.cnt = '0;
    end else if (en) begin
      if (d_reg.cnt == LAST) begin
        d_next.cnt  = '0;
        d_next.tick = 1'b1;
      end else begin
        d_next.cnt = d_reg.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

  assign tick = d_reg.tick;

endmodule

// ==== ccsr_regs.sv ====
// charger control and status register bank with phase sequencer and timers
`timescale 1ns/1ps

// Functional notes
// - Three 5-bit charge-current codes for regions 4, 3 and 2 live in bits 14:10, 9:5, 4:0.
// - After reset the region 4 and 3 codes read 31 and the region 2 code reads 15.
// - Option bit 2 (reset 0) ends charging when current drops to C/x during constant voltage.
// - Option bit 0 (reset 1) enables temperature-qualified charging; the register resets to 1.
// - With a nonzero charge-time limit a read-only counter shows minutes spent charging since cycle start.
// - Charging ends when the minute counter reaches a nonzero charge-time limit.
// - A read-only counter shows seconds spent in the constant-voltage phase.
// - Charging completes once the constant-voltage seconds exceed the cv time limit.
// - A read-only 13-bit one-hot register shows the charger phase and resets to 256.
// - A read-only 6-bit register flags one active loop, only while charging, else zero.
// - An alert bit sets only while enabled and stays high until cleared or disabled.
// - Writing the alert register clears the bits written as zero, except those set again in the same cycle.
// - Alert bit 15 sets once the telemetry warm-up has expired.
// - Dropping the telemetry-valid enable clears that alert bit too.
module ccsr_regs
  import ccsr_pkg::*;
#(
  parameter longint SEC_CYCLES = ccsr_pkg::SECOND_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_cmd,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [15:0] max_charge_time,
  input  wire logic [15:0] cv_time_limit,
  input  wire logic [15:0] alert_enable,
  input  wire logic        charge_enable_pin,
  input  wire logic        bat_present_pin,
  input  wire logic        bat_short_pin,
  input  wire logic        detect_done_pin,
  input  wire logic        detect_fail_pin,
  input  wire logic        bat_low_pin,
  input  wire logic        therm_fault_pin,
  input  wire logic        ibat_below_cx_pin,
  input  wire logic [5:0]  loop_active_pin,
  input  wire logic [14:0] limit_event_pin,
  input  wire logic        telemetry_ready_pin,
  output logic      [14:0] icharge_codes,
  output logic      [2:0]  option_bits,
  output logic      [12:0] phase_onehot,
  output logic             charging
);

  // ******************************************************************
  // state and pin synchronisation
  // ******************************************************************
  typedef struct packed {
    logic [14:0] icharge;
    logic [2:0]  option;
    logic [15:0] minutes;
    logic [15:0] cv_secs;
    ccsr_state_t state;
    logic [12:0] onehot;
    logic        charging;
    logic [15:0] alerts;
    logic [5:0]  loops;
    logic        in_cv;
    logic [15:0] rdata;
    logic        rvalid;
  } ccsr_regs_t;

  localparam int PIN_W = 30;

  ccsr_regs_t r_reg;
  ccsr_regs_t r_next;

  logic [PIN_W-1:0] pins_sync;
  logic        chg_en;
  logic        bat_ok;
  logic        bat_short;
  logic        det_done;
  logic        det_fail;
  logic        bat_low;
  logic        therm_fault;
  logic        below_cx;
  logic [5:0]  loop_raw;
  logic [14:0] limit_ev;
  logic        telem_ready;
  logic        sec_tick;
  logic        min_tick;
  logic        cycle_start;
  logic        min_run;

  ccsr_sync2 #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({charge_enable_pin, bat_present_pin, bat_short_pin, detect_done_pin,
             detect_fail_pin, bat_low_pin, therm_fault_pin, ibat_below_cx_pin,
             loop_active_pin, limit_event_pin, telemetry_ready_pin}),
    .q     (pins_sync)
  );

  assign {chg_en, bat_ok, bat_short, det_done, det_fail, bat_low, therm_fault,
          below_cx, loop_raw, limit_ev, telem_ready} = pins_sync;

  // ******************************************************************
  // time bases
  // ******************************************************************
  // both dividers restart with the cycle; a later cv entry may see a short first second
  assign cycle_start = (r_reg.state == ST_DETECTING) && (r_next.state != ST_DETECTING);
  assign min_run     = r_reg.charging && (max_charge_time != COUNT_RESET);

  ccsr_tick_div #(
    .COUNT (int'(SEC_CYCLES))
  ) u_sec_div (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (1'b1),
    .clr   (cycle_start),
    .tick  (sec_tick)
  );

  ccsr_tick_div #(
    .COUNT (MINUTE_SECONDS)
  ) u_min_div (
    .clk   (clk),
    .rst_b (rst_b),
    .en    (sec_tick && min_run),
    .clr   (cycle_start),
    .tick  (min_tick)
  );

  function automatic logic [12:0] phase_code(input ccsr_state_t s);
    case (s)
      ST_SUSPENDED:     phase_code = PH_SUSPENDED;
      ST_DETECTING:     phase_code = PH_DETECTING;
      ST_DETECT_FAILED: phase_code = PH_DETECT_FAILED;
      ST_PRECHARGE:     phase_code = PH_PRECHARGE;
      ST_MAIN_CHARGING: phase_code = PH_MAIN_CHARGING;
      ST_THERM_PAUSE:   phase_code = PH_THERM_PAUSE;
      ST_TIMER_DONE:    phase_code = PH_TIMER_DONE;
      ST_CX_DONE:       phase_code = PH_CX_DONE;
      ST_TIME_FAULT:    phase_code = PH_TIME_FAULT;
      ST_MISSING:       phase_code = PH_MISSING;
      ST_SHORT:         phase_code = PH_SHORT;
      default:          phase_code = PH_SUSPENDED;
    endcase
  endfunction

  // keeps only the highest active loop so the flags stay one-hot
  function automatic logic [5:0] one_loop(input logic [5:0] v);
    one_loop = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (v[i]) begin
        one_loop = 6'h01 << i;
      end
    end
  endfunction

  // ******************************************************************
  // next-state logic
  // ******************************************************************
  logic        time_up;
  logic        cv_up;
  logic        cx_done;
  logic        cv_now;
  logic [15:0] alert_set;
  logic [15:0] alert_keep;

  always_comb begin
    r_next        = r_reg;
    r_next.rvalid = 1'b0;

    time_up = (max_charge_time != COUNT_RESET) && (r_reg.minutes >= max_charge_time);
    cv_up   = r_reg.in_cv && (r_reg.cv_secs > cv_time_limit);
    cx_done = r_reg.option[OPT_CX_TERM_BIT] && r_reg.in_cv && below_cx;

    // phase sequencer
    case (r_reg.state)
      ST_SUSPENDED: begin
        if (chg_en) begin
          r_next.state = ST_DETECTING;
        end
      end
      ST_DETECTING: begin
        if (!chg_en) begin
          r_next.state = ST_SUSPENDED;
        end else if (det_fail) begin
          r_next.state = ST_DETECT_FAILED;
        end else if (det_done) begin
          r_next.state = bat_low ? ST_PRECHARGE : ST_MAIN_CHARGING;
        end
      end
      ST_PRECHARGE,
      ST_MAIN_CHARGING,
      ST_THERM_PAUSE: begin
        if (!chg_en) begin
          r_next.state = ST_SUSPENDED;
        end else if (bat_short) begin
          r_next.state = ST_SHORT;
        end else if (!bat_ok) begin
          r_next.state = ST_MISSING;
        end else if (time_up) begin
          r_next.state = (r_reg.state == ST_PRECHARGE) ? ST_TIME_FAULT : ST_TIMER_DONE;
        end else if (cv_up) begin
          r_next.state = ST_TIMER_DONE;
        end else if (cx_done) begin
          r_next.state = ST_CX_DONE;
        end else if (r_reg.option[OPT_TEMP_QUAL_BIT] && therm_fault) begin
          r_next.state = ST_THERM_PAUSE;
        end else if (r_reg.state == ST_THERM_PAUSE) begin
          r_next.state = bat_low ? ST_PRECHARGE : ST_MAIN_CHARGING;
        end else if (r_reg.state == ST_PRECHARGE && !bat_low) begin
          r_next.state = ST_MAIN_CHARGING;
        end
      end
      ST_DETECT_FAILED,
      ST_TIMER_DONE,
      ST_CX_DONE,
      ST_TIME_FAULT,
      ST_MISSING,
      ST_SHORT: begin
        // terminal phases hold until the charger is disabled
        if (!chg_en) begin
          r_next.state = ST_SUSPENDED;
        end
      end
      default: begin
        r_next.state = ST_SUSPENDED;
      end
    endcase

    r_next.onehot   = phase_code(r_next.state);
    r_next.charging = (r_next.state == ST_PRECHARGE) || (r_next.state == ST_MAIN_CHARGING);

    // loop flags only in charging phases
    r_next.loops = r_next.charging ? one_loop(loop_raw) : 6'h00;
    cv_now       = (r_next.state == ST_MAIN_CHARGING) && loop_raw[0];
    r_next.in_cv = cv_now;

    if ((r_reg.state == ST_DETECTING) && (r_next.state != ST_DETECTING)) begin
      r_next.minutes = COUNT_RESET;
    end else if (min_tick && r_reg.minutes != COUNT_SAT) begin
      r_next.minutes = r_reg.minutes + 16'h0001;
    end

    if (cv_now && !r_reg.in_cv) begin
      r_next.cv_secs = COUNT_RESET;
    end else if (cv_now && sec_tick && r_reg.cv_secs != COUNT_SAT) begin
      r_next.cv_secs = r_reg.cv_secs + 16'h0001;
    end

    alert_set  = {telem_ready, limit_ev} & alert_enable;
    alert_keep = r_reg.alerts;
    if (reg_wr && reg_cmd == CMD_ALERT_FLAGS) begin
      alert_keep = r_reg.alerts & reg_wdata;
    end
    // set beats clear; dropped enable clears the bit
    r_next.alerts = (alert_keep | alert_set) & alert_enable;

    // host writes
    if (reg_wr) begin
      case (reg_cmd)
        CMD_ICHARGE_REGIONS: begin
          r_next.icharge = reg_wdata[14:0];
        end
        CMD_OPTION_BITS: begin
          r_next.option = reg_wdata[2:0];
        end
        default: begin
          r_next.icharge = r_next.icharge;
        end
      endcase
    end

    // host reads, unmapped codes read zero
    if (reg_rd) begin
      r_next.rvalid = 1'b1;
      case (reg_cmd)
        CMD_ICHARGE_REGIONS: r_next.rdata = {1'b0, r_reg.icharge};
        CMD_OPTION_BITS:     r_next.rdata = {13'h0000, r_reg.option};
        CMD_CYCLE_MINUTES:   r_next.rdata = r_reg.minutes;
        CMD_CV_SECONDS:      r_next.rdata = r_reg.cv_secs;
        CMD_PHASE_ONEHOT:    r_next.rdata = {3'h0, r_reg.onehot};
        CMD_LOOP_FLAGS:      r_next.rdata = {10'h000, r_reg.loops};
        CMD_ALERT_FLAGS:     r_next.rdata = r_reg.alerts;
        default:             r_next.rdata = 16'h0000;
      endcase
    end
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg.icharge  <= {ICH_R4_RESET, ICH_R3_RESET, ICH_R2_RESET};
      r_reg.option   <= OPT_RESET;
      r_reg.minutes  <= COUNT_RESET;
      r_reg.cv_secs  <= COUNT_RESET;
      r_reg.state    <= ST_SUSPENDED;
      r_reg.onehot   <= PH_SUSPENDED;
      r_reg.charging <= 1'b0;
      r_reg.alerts   <= ALERT_RESET;
      r_reg.loops    <= 6'h00;
      r_reg.in_cv    <= 1'b0;
      r_reg.rdata    <= 16'h0000;
      r_reg.rvalid   <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata     = r_reg.rdata;
  assign reg_rvalid    = r_reg.rvalid;
  assign icharge_codes = r_reg.icharge;
  assign option_bits   = r_reg.option;
  assign phase_onehot  = r_reg.onehot;
  assign charging      = r_reg.charging;

endmodule

// ==== ccsr_regs_asserts.sv ====
// port-level checks of the charger register bank
`timescale 1ns/1ps
module ccsr_regs_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_cmd,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [15:0] alert_enable,
  input wire logic [14:0] icharge_codes,
  input wire logic [2:0]  option_bits,
  input wire logic [12:0] phase_onehot
);
  import ccsr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ****
  // read and write request steps
  // ****
  sequence s_rd(logic [7:0] c);
    reg_rd && reg_cmd == c;
  endsequence
  sequence s_wr(logic [7:0] c);
    reg_wr && reg_cmd == c;
  endsequence
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  a_phase_onehot: assert property ($onehot(phase_onehot))
    else $error("phase not one-hot");
  a_phase_read: assert property (s_rd(CMD_PHASE_ONEHOT) |=> reg_rdata == {3'h0, $past(phase_onehot)})
    else $error("phase read mismatch");
  a_code_read: assert property (s_rd(CMD_ICHARGE_REGIONS) |=> reg_rdata == {1'b0, $past(icharge_codes)})
    else $error("code read mismatch");
  a_code_write: assert property (s_wr(CMD_ICHARGE_REGIONS) |=> icharge_codes == $past(reg_wdata[14:0]))
    else $error("code write not stored");
  a_option_read: assert property (s_rd(CMD_OPTION_BITS) |=> reg_rdata == {13'h0000, $past(option_bits)})
    else $error("option read mismatch");
  a_loop_single: assert property (s_rd(CMD_LOOP_FLAGS) |=> $onehot0(reg_rdata[5:0]) && reg_rdata[15:6] == 10'h000)
    else $error("more than one loop flagged");
  a_alert_masked: assert property (s_rd(CMD_ALERT_FLAGS) |=> (reg_rdata & ~$past(alert_enable, 2)) == 16'h0000)
    else $error("alert set while disabled");
  a_unmapped_zero: assert property (s_rd(8'h00) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind ccsr_regs ccsr_regs_asserts u_ccsr_regs_asserts (
  .clk(clk), .rst_b(rst_b), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alert_enable(alert_enable),
  .icharge_codes(icharge_codes), .option_bits(option_bits), .phase_onehot(phase_onehot)
);

// ==== ccsr_host_model.sv ====
// host controller model that drives the register command port
`timescale 1ns/1ps
module ccsr_host_model (
  input  wire logic        clk,
  output logic      [7:0]  reg_cmd,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  import ccsr_pkg::*;
  initial begin
    reg_cmd = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic do_write(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_cmd = c;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_cmd = ~c;
  endtask
  task automatic do_read(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk);
    #1;
    reg_cmd = c;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_cmd = ~c;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
  endtask
  task automatic clear_alert(input int b);
    do_write(CMD_ALERT_FLAGS, ~(16'h0001 << b));
  endtask
endmodule

// ==== ccsr_regs_tb.sv ====
// self-checking bench for the charger register bank
`timescale 1ns/1ps
module ccsr_regs_tb;
  import ccsr_pkg::*;
  logic        clk, rst_b, reg_wr, reg_rd, reg_rvalid, chg_en, bat_pres, det_done;
  logic        bat_low, cx_pin, telem_pin, charging, short_pin, fail_pin, therm_pin;
  logic [7:0]  reg_cmd;
  logic [15:0] reg_wdata, reg_rdata, max_t, cv_lim, alert_en, rd_v;
  logic [5:0]  loop_pin;
  logic [14:0] event_pin, icharge_codes;
  logic [2:0]  option_bits;
  logic [12:0] phase_onehot;
  int          err_count, samples_checked, cyc;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // short second keeps the minute timer within a few hundred cycles
  ccsr_regs #(.SEC_CYCLES(10)) u_ccsr_regs (
    .clk(clk), .rst_b(rst_b), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .max_charge_time(max_t),
    .cv_time_limit(cv_lim), .alert_enable(alert_en), .charge_enable_pin(chg_en),
    .bat_present_pin(bat_pres), .bat_short_pin(short_pin), .detect_done_pin(det_done),
    .detect_fail_pin(fail_pin), .bat_low_pin(bat_low), .therm_fault_pin(therm_pin),
    .ibat_below_cx_pin(cx_pin), .loop_active_pin(loop_pin), .limit_event_pin(event_pin),
    .telemetry_ready_pin(telem_pin), .icharge_codes(icharge_codes), .option_bits(option_bits),
    .phase_onehot(phase_onehot), .charging(charging)
  );
  ccsr_host_model u_ccsr_host_model (
    .clk(clk), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ph(input logic [12:0] e);
    samples_checked++;
    if (phase_onehot !== e) begin
      err_count++;
      $display("ERROR phase expected %h seen %h", e, phase_onehot);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] c, input logic [15:0] e);
    u_ccsr_host_model.do_read(c, rd_v);
    chk_reg(nm, e, rd_v);
  endtask
  task automatic wait_ph(input logic [12:0] e, input int lim);
    for (int i = 0; i < lim && phase_onehot !== e; i++) step(1);
    chk_ph(e);
  endtask
  task automatic start_chg();
    chg_en = 1'b1;
    bat_pres = 1'b1;
    wait_ph(PH_DETECTING, 20);
    det_done = 1'b1;
    wait_ph(PH_MAIN_CHARGING, 20);
  endtask
  task automatic stop_chg();
    chg_en = 1'b0;
    det_done = 1'b0;
    wait_ph(PH_SUSPENDED, 20);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      $display("ERROR run_time expected %0d seen %0d", 4999, cyc);
      wrap_up();
    end
  end

  initial begin
    {err_count, samples_checked, cyc} = 0;
    {rst_b, chg_en, bat_pres, det_done, bat_low, cx_pin, telem_pin} = 7'h00;
    {short_pin, fail_pin, therm_pin} = 3'h0;
    {max_t, alert_en, loop_pin, event_pin} = '0;
    cv_lim = 16'hFFFF;
    step(12);
    rst_b = 1'b1;
    rd_chk("codes", CMD_ICHARGE_REGIONS, {1'b0, ICH_R4_RESET, ICH_R3_RESET, ICH_R2_RESET});
    rd_chk("options", CMD_OPTION_BITS, 16'h0001);
    rd_chk("minutes", CMD_CYCLE_MINUTES, 16'h0000);
    rd_chk("cv_secs", CMD_CV_SECONDS, 16'h0000);
    rd_chk("phase", CMD_PHASE_ONEHOT, 16'h0100);
    rd_chk("loops", CMD_LOOP_FLAGS, 16'h0000);
    rd_chk("alerts", CMD_ALERT_FLAGS, 16'h0000);
    rd_chk("unmapped", 8'h00, 16'h0000);
    $display("test reset values done");
    u_ccsr_host_model.do_write(CMD_ICHARGE_REGIONS, 16'h2A5B);
    rd_chk("codes", CMD_ICHARGE_REGIONS, 16'h2A5B);
    u_ccsr_host_model.do_write(CMD_ICHARGE_REGIONS, 16'hFFFF);
    chk_reg("code_pins", 16'h7FFF, {1'b0, icharge_codes});
    u_ccsr_host_model.do_write(CMD_OPTION_BITS, 16'hFFFF);
    rd_chk("options", CMD_OPTION_BITS, 16'h0007);
    u_ccsr_host_model.do_write(CMD_PHASE_ONEHOT, 16'h0000);
    rd_chk("phase", CMD_PHASE_ONEHOT, 16'h0100);
    u_ccsr_host_model.do_write(CMD_CYCLE_MINUTES, 16'h1234);
    rd_chk("minutes", CMD_CYCLE_MINUTES, 16'h0000);
    u_ccsr_host_model.do_write(CMD_OPTION_BITS, 16'h0001);
    $display("test register access done");
    event_pin = 15'h0001;
    step(4);
    rd_chk("alerts", CMD_ALERT_FLAGS, 16'h0000);
    event_pin = 15'h0000;
    alert_en = 16'hFFFF;
    step(4);
    event_pin = 15'h0009;
    step(1);
    event_pin = 15'h0000;
    step(4);
    rd_chk("alerts", CMD_ALERT_FLAGS, 16'h0009);
    u_ccsr_host_model.clear_alert(0);
    rd_chk("alerts", CMD_ALERT_FLAGS, 16'h0008);
    alert_en = 16'hFFF7;
    step(2);
    rd_chk("alerts", CMD_ALERT_FLAGS, 16'h0000);
    telem_pin = 1'b1;
    step(4);
    rd_chk("alerts", CMD_ALERT_FLAGS, 16'h8000);
    alert_en = 16'h7FFF;
    step(2);
    rd_chk("alerts", CMD_ALERT_FLAGS, 16'h0000);
    $display("test alerts done");
    loop_pin = 6'h03;
    cv_lim = 16'h0002;
    start_chg();
    step(3);
    rd_chk("loops", CMD_LOOP_FLAGS, 16'h0002);
    wait_ph(PH_TIMER_DONE, 100);
    stop_chg();
    cv_lim = 16'hFFFF;
    u_ccsr_host_model.do_write(CMD_OPTION_BITS, 16'h0005);
    start_chg();
    cx_pin = 1'b1;
    wait_ph(PH_CX_DONE, 20);
    stop_chg();
    cx_pin = 1'b0;
    u_ccsr_host_model.do_write(CMD_OPTION_BITS, 16'h0001);
    $display("test cv and c/x termination done");
    max_t = 16'h0001;
    loop_pin = 6'h02;
    start_chg();
    step(500);
    chk_ph(PH_MAIN_CHARGING);
    wait_ph(PH_TIMER_DONE, 200);
    rd_chk("minutes", CMD_CYCLE_MINUTES, 16'h0001);
    stop_chg();
    loop_pin = 6'h01;
    start_chg();
    rd_chk("minutes", CMD_CYCLE_MINUTES, 16'h0000);
    rd_chk("cv_secs", CMD_CV_SECONDS, 16'h0000);
    stop_chg();
    $display("test charge timers done");
    max_t = 16'h0000;
    start_chg();
    chk_reg("charging", 16'h0001, {15'h0000, charging});
    chk_reg("option_pins", 16'h0001, {13'h0000, option_bits});
    therm_pin = 1'b1;
    wait_ph(PH_THERM_PAUSE, 20);
    therm_pin = 1'b0;
    wait_ph(PH_MAIN_CHARGING, 20);
    u_ccsr_host_model.do_write(CMD_OPTION_BITS, 16'h0000);
    therm_pin = 1'b1;
    step(6);
    chk_ph(PH_MAIN_CHARGING);
    therm_pin = 1'b0;
    bat_pres = 1'b0;
    wait_ph(PH_MISSING, 20);
    stop_chg();
    chk_reg("charging", 16'h0000, {15'h0000, charging});
    start_chg();
    short_pin = 1'b1;
    wait_ph(PH_SHORT, 20);
    stop_chg();
    short_pin = 1'b0;
    chg_en = 1'b1;
    wait_ph(PH_DETECTING, 20);
    fail_pin = 1'b1;
    wait_ph(PH_DETECT_FAILED, 20);
    stop_chg();
    fail_pin = 1'b0;
    max_t = 16'h0001;
    bat_low = 1'b1;
    chg_en = 1'b1;
    wait_ph(PH_DETECTING, 20);
    det_done = 1'b1;
    wait_ph(PH_PRECHARGE, 20);
    wait_ph(PH_TIME_FAULT, 700);
    stop_chg();
    bat_low = 1'b0;
    $display("test phase codes done");
    wrap_up();
  end
endmodule
